// ### sim/fpb_array_model.sv
// behavioural flash array answering reads after a set delay
module fpb_array_model (
  input wire logic sys_clk_i,
  input wire logic rd_i,
  input wire logic [22:0] addr_i,
  input wire logic [7:0] lat_i,
  output logic rvalid_o = 1'b0,
  output logic [15:0] rdata_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [22:0] pend_a[$];
  int pend_t[$];
  int cyc = 0;

  // queue keeps prefetched reads in order; data toggles when not valid
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    rvalid_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (pend_t.size() > 0 && pend_t[0] <= cyc) begin
      rvalid_o <= 1'b1;
      rdata_o <= pend_a[0][15:0] ^ 16'h5a5a;
      void'(pend_a.pop_front());
      void'(pend_t.pop_front());
    end
    if (rd_i) begin
      pend_a.push_back(addr_i);
      pend_t.push_back(cyc + int'(lat_i));
    end
  end
endmodule : fpb_array_model

// ### sim/fpb_top_asserts.sv
// concurrent checks on the flash port pins
`include "fpb_defs.svh"
module fpb_top_asserts import fpb_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic reset_n_i,
  input wire fpb_cfg_t cfg_i,
  input wire logic data_oe_o,
  input wire logic wait_o,
  input wire logic wait_oe_o,
  input wire logic sector_protected_i,
  input wire logic erase_busy_i,
  input wire logic erase_start_o,
  input wire fpb_erase_cmd_t erase_cmd_o,
  input wire logic erase_abort_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // six cycles cover the pin synchroniser and output flop
  property p_oe_float;
    out_en_n_i [*6] |=> !wait_oe_o && !data_oe_o;
  endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("outputs driven with output enable high");

  property p_ce_float;
    chip_sel_n_i [*6] |=> !wait_oe_o && !data_oe_o;
  endproperty
  a_ce_float: assert property (p_ce_float)
    else $error("outputs driven with chip select high");

  property p_pin_rst;
    !reset_n_i [*6] |=> !data_oe_o && !wait_oe_o && !erase_start_o;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("activity while reset pin low");

  property p_abort;
    (!reset_n_i && erase_busy_i) [*6] |=> erase_abort_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("erase not aborted by reset pin");

  property p_abort_cause;
    erase_abort_o |-> $past(erase_busy_i) && !$past(reset_n_i, 2);
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without busy erase and reset pin");

  // one start per command, commands need a full strobe
  property p_start_pulse;
    erase_start_o |=> !erase_start_o [*4];
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("erase start longer than one cycle");

  property p_protect;
    erase_start_o && erase_cmd_o.kind == FPB_ER_SECTOR
      |-> !sector_protected_i;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected sector erased");

  property p_kind;
    erase_start_o |-> erase_cmd_o.kind != 2'h3;
  endproperty
  a_kind: assert property (p_kind)
    else $error("erase started with no scope");

  property p_wait_data;
    wait_oe_o && wait_o && !cfg_i.wait_polarity_bit |-> data_oe_o;
  endproperty
  a_wait_data: assert property (p_wait_data)
    else $error("wait says valid but data not driven");
endmodule : fpb_top_asserts

bind fpb_top fpb_top_asserts u_asserts (.sys_clk_i, .sys_rst_i,
  .chip_sel_n_i, .out_en_n_i, .reset_n_i, .cfg_i, .data_oe_o, .wait_o,
  .wait_oe_o, .sector_protected_i, .erase_busy_i, .erase_start_o,
  .erase_cmd_o, .erase_abort_o);

// ### sim/testbench.sv
// self-checking bench for the flash read and erase port
`include "fpb_defs.svh"
module testbench import fpb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, sys_rst_i = 1;
  logic ce_n = 1, oe_n = 1, we_n = 1, av_n = 1, bclk = 0, rst_n = 1;
  logic [22:0] addr = '0, aaddr;
  logic [15:0] din = '0, dout, rdata;
  logic doe, wt, woe, rd, rv, prot = 0, busy = 0, est, eab;
  logic [7:0] alat = 8'h02;
  fpb_cfg_t cfg = '0;
  fpb_erase_cmd_t ecmd, kd;
  int num_errors = 0, n_tests = 0, n, ne, gaps, f2;
  logic [15:0] got[$];
  int at[$];
  logic [7:0] cmds[5] = '{`FPB_CMD_CHIP, `FPB_CMD_PLANE, `FPB_CMD_SECTOR,
    `FPB_CMD_SECTOR, 8'h55};

  always #4 sys_clk_i = ~sys_clk_i;

  fpb_top #(.FIFO_DEPTH(8)) dut (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .chip_sel_n_i(ce_n), .out_en_n_i(oe_n),
    .write_n_i(we_n), .addr_valid_n_i(av_n), .burst_clk_i(bclk),
    .reset_n_i(rst_n), .addr_i(addr), .data_i(din), .cfg_i(cfg),
    .data_o(dout), .data_oe_o(doe), .wait_o(wt), .wait_oe_o(woe),
    .array_rd_o(rd), .array_addr_o(aaddr), .array_rvalid_i(rv),
    .array_rdata_i(rdata), .sector_protected_i(prot),
    .erase_busy_i(busy), .erase_start_o(est), .erase_cmd_o(ecmd),
    .erase_abort_o(eab));

  fpb_array_model u_array (.sys_clk_i(sys_clk_i), .rd_i(rd),
    .addr_i(aaddr), .lat_i(alat), .rvalid_o(rv), .rdata_o(rdata));

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  function automatic logic [15:0] wd(input logic [22:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction : wd

  task automatic chk(input string what, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // page access; burst clock toggles throughout to show it is ignored
  task automatic page_go(input logic [22:0] a, output int k);
    addr = a;
    k = 0;
    do begin
      bclk = ~bclk;
      cyc(1);
      k++;
    end while (!(doe === 1'b1 && dout === wd(a)) && k < 60);
  endtask : page_go

  // one burst, ten cycles per clock so the synchroniser keeps up
  task automatic burst(input logic [22:0] a, input int np, sp);
    logic [15:0] last;
    last = ~wd(a);
    got = {};
    at = {};
    ce_n = 1; oe_n = 1; av_n = 1; bclk = ~cfg.clock_edge_bit; cyc(8);
    addr = a; ce_n = 0; oe_n = 0; av_n = 0; cyc(5);
    for (int i = 0; i < np; i++) begin
      bclk = ~bclk; cyc(5);
      av_n = 1;
      bclk = ~bclk; cyc(5);
      if (i == sp) begin
        oe_n = 1; cyc(40);
        chk("suspend wait oe", 0, woe);
        oe_n = 0; cyc(6);
      end
      if (woe === 1'b1 && wt === !cfg.wait_polarity_bit && dout !== last) begin
        last = dout;
        got.push_back(dout);
        at.push_back(i);
      end
    end
    ce_n = 1; cyc(8);
    chk("end float", 0, {doe, woe});
  endtask : burst

  // word values follow the burst order; w zero means linear
  task automatic chk_seq(input logic [22:0] a, input int cnt, w);
    logic [22:0] m;
    m = 23'(w - 1);
    gaps = 0;
    if (cnt >= 0) chk("word count", cnt, got.size());
    foreach (got[k]) begin
      chk("word", w ? wd((a & ~m) | (23'(a + k) & m)) : wd(a + k), got[k]);
      if (k > 0 && at[k] - at[k-1] != 1) gaps++;
    end
  endtask : chk_seq

  // one command write, counting erase starts in the ten cycles after its strobe
  task automatic wr(input logic [22:0] a, input logic [7:0] b);
    addr = a; din = {8'h00, b}; ce_n = 0; oe_n = 1; cyc(5);
    we_n = 0; cyc(5);
    we_n = 1;
    ne = 0;
    repeat (10) begin
      cyc(1);
      if (est === 1'b1) begin
        ne++;
        kd = ecmd;
      end
    end
  endtask : wr

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    cyc(20000);
    num_errors++;
    print_verdict();
  end

  initial begin
    cyc(10);
    sys_rst_i = 0;
    cyc(6);
    // page reads, four then eight words, slow first array answer
    cfg.read_type_bit = 1'b1;
    ce_n = 0; oe_n = 0; av_n = 0;
    for (int s = 0; s < 2; s++) begin
      cfg.page_size_bit = s[0];
      alat = 8'h0a;
      page_go(23'h012340 + 23'(s * 64), n);
      chk("first word", 1, n >= `FPB_FIRST_CYC && n < 60);
      alat = 8'h02;
      page_go(23'h012341 + 23'(s * 64), n);
      chk("page word", 1, n < `FPB_FIRST_CYC);
      page_go(23'h012345 + 23'(s * 64), n);
      chk("bit two in page", s, n < `FPB_FIRST_CYC);
    end
    // strobe rise holds the page against later pin changes
    av_n = 1; cyc(5);
    av_n = 0;
    page_go(23'h020010, n);
    av_n = 1; cyc(6);
    addr = 23'h020410; cyc(24);
    chk("latched page", wd(23'h020010), dout);
    rst_n = 0; cyc(8);
    chk("reset pin float", 0, doe);
    rst_n = 1; cyc(6);
    av_n = 0;
    page_go(23'h030020, n);
    chk("read after reset pin", 1, n < 60);
    // fixed bursts, wrapping, rising and falling clock edge
    cfg = '0;
    cfg.latency_field = 3'h3;
    cfg.linear_burst_bit = 1'b1;
    for (int e = 0; e < 2; e++) begin
      for (int l = 1; l < 4; l++) begin
        cfg.clock_edge_bit = e[0];
        cfg.burst_len = 3'(l);
        // start at 14 so a gap would show if the wrap bit were ignored
        burst(23'h0003ae, (4 << (l - 1)) + 12, -1);
        chk_seq(23'h0003ae, 4 << (l - 1), 4 << (l - 1));
        chk("no wrap gap", 0, gaps);
      end
    end
    // latency codes two and six differ by four clocks
    cfg.clock_edge_bit = 1'b1;
    cfg.burst_len = `FPB_LEN_CONT;
    cfg.latency_field = `FPB_LAT_MIN;
    burst(23'h000100, 12, -1);
    f2 = at[0];
    // inverted wait polarity: valid words now show wait low
    cfg.latency_field = `FPB_LAT_MAX;
    cfg.wait_polarity_bit = 1'b1;
    burst(23'h000100, 12, -1);
    chk("latency span", 4, at[0] - f2);
    chk_seq(23'h000100, 6, 0);
    cfg.wait_polarity_bit = 1'b0;
    // boundary gap from start 13 only, suspend from start 12
    cfg.latency_field = 3'h3;
    cfg.burst_wrap_bit = 1'b1;
    burst(23'h00001d, 16, -1);
    chk_seq(23'h00001d, -1, 0);
    chk("boundary gap", 4, at[3] - at[2]);
    chk("one gap", 1, gaps);
    burst(23'h00001c, 18, 6);
    chk_seq(23'h00001c, -1, 0);
    chk("no gap from 12", 0, gaps);
    // erase commands: chip, plane, sector, protected, bad byte
    for (int i = 0; i < 5; i++) begin
      prot = (i == 3);
      wr(23'h000000, `FPB_CMD_SETUP);
      chk("setup only", 0, ne);
      wr(23'h5a8000, cmds[i]);
      chk("erase starts", i < 3, ne);
      if (i < 3) chk("erase kind", i, kd.kind);
      if (i == 1 || i == 2) chk("erase addr", 23'h5a8000, kd.addr);
    end
    // reset pin during a running erase
    prot = 0;
    busy = 1;
    wr(23'h000000, `FPB_CMD_SETUP);
    wr(23'h000000, `FPB_CMD_CHIP);
    rst_n = 0; cyc(8);
    chk("erase abort", 1, eab);
    rst_n = 1; busy = 0; ce_n = 1; cyc(8);
    print_verdict();
  end
endmodule : testbench

// ### src/fpb_defs.svh
// timing, field and command constants for the flash read and erase port
`ifndef FPB_DEFS_SVH
`define FPB_DEFS_SVH
`define FPB_CLK_PERIOD_NS 8
`define FPB_T_FIRST_NS 90
`define FPB_T_PAGE_NS 20
// least times round up to whole cycles
`define FPB_FIRST_CYC ((`FPB_T_FIRST_NS + `FPB_CLK_PERIOD_NS - 1) / `FPB_CLK_PERIOD_NS)
`define FPB_PAGE_CYC ((`FPB_T_PAGE_NS + `FPB_CLK_PERIOD_NS - 1) / `FPB_CLK_PERIOD_NS)
`define FPB_TMR_W 5
`define FPB_ADDR_W 23
`define FPB_DATA_W 16
`define FPB_LAT_MIN 3'h2
`define FPB_LAT_MAX 3'h6
`define FPB_GRP_W 4
`define FPB_GAP_FIRST 4'hd
`define FPB_LEN_CONT 3'h0
`define FPB_LEN_4 3'h1
`define FPB_LEN_8 3'h2
`define FPB_LEN_16 3'h3
`define FPB_PLANE_LSB 18
`define FPB_SECTOR_LSB 15
// erase command bytes, values arbitrary
`define FPB_CMD_SETUP 8'h20
`define FPB_CMD_CHIP 8'h10
`define FPB_CMD_PLANE 8'h30
`define FPB_CMD_SECTOR 8'hd0
`define FPB_CMD_BYTE_W 8
`define FPB_SYNC_W 6
`endif

// ### src/fpb_fifo.sv
// flip-flop fifo with valid and ready on both sides and a flush
module fpb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count, wrap for non power of two depth
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fpb_fifo

// ### src/fpb_pkg.sv
// types shared by the flash read and erase port
package fpb_pkg;
  typedef struct packed {
    logic read_type_bit;
    logic page_size_bit;
    logic [2:0] latency_field;
    logic wait_polarity_bit;
    logic wait_timing_bit;
    logic linear_burst_bit;
    logic clock_edge_bit;
    logic burst_wrap_bit;
    logic [2:0] burst_len;
  } fpb_cfg_t;

  typedef enum logic [1:0] {
    FPB_ER_CHIP = 2'b00,
    FPB_ER_PLANE = 2'b01,
    FPB_ER_SECTOR = 2'b10
  } fpb_er_kind_t;

  typedef struct packed {
    fpb_er_kind_t kind;
    logic [22:0] addr;
  } fpb_erase_cmd_t;

  typedef enum logic [2:0] {
    FPB_IDLE = 3'b000,
    FPB_PAGE = 3'b001,
    FPB_BLAT = 3'b010,
    FPB_BDATA = 3'b011,
    FPB_BGAP = 3'b100,
    FPB_BDONE = 3'b101
  } fpb_state_t;
endpackage : fpb_pkg

// ### src/fpb_sync.sv
// three-stage pin synchroniser, a change counts once stages two and three agree
module fpb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // stage one feeds stage two only
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit agreement filter
  for (genvar i = 0; i < WIDTH; i++) begin : g_agree
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
        level_o[i] <= INIT[i];
      end else if (s2_q[i] == s3_q[i]) begin
        level_o[i] <= s3_q[i];
      end
    end
  end
endmodule : fpb_sync

// ### src/fpb_top.sv
// flash page, burst read and erase entry front end
// Functional notes
// - page read ignores burst clock entirely
// - page size four or eight words
// - pulsed strobe latches page address rising
// - first word 90 ns, page words 20 ns
// - burst start latched on first event
// - after latency one word per clock
// - start 13-15 linear wrap adds one gap
// - wait low without new data, high valid
// - wait floats when select or enable high
// - fixed bursts give four, eight, sixteen words
// - wrapping bursts insert no boundary gap
// - suspend keeps sensing and latched data
// - resume continues burst where it stopped
// - enable high floats wait during suspend
// - reset pin halts, floats, returns read
// - erase sets bits to one, three scopes
// - chip erase starts on final strobe
// - plane erase uses second strobe address
// - sector erase only when unprotected
// - read type selects burst or asynchronous
// - latency field gives two to six cycles
// - clock edge bit picks active edge
`include "fpb_defs.svh"
module fpb_top import fpb_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic write_n_i,
  input wire logic addr_valid_n_i,
  input wire logic burst_clk_i,
  input wire logic reset_n_i,
  input wire logic [`FPB_ADDR_W-1:0] addr_i,
  input wire logic [`FPB_DATA_W-1:0] data_i,
  input wire fpb_cfg_t cfg_i,
  output logic [`FPB_DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic wait_o,
  output logic wait_oe_o,
  output logic array_rd_o,
  output logic [`FPB_ADDR_W-1:0] array_addr_o,
  input wire logic array_rvalid_i,
  input wire logic [`FPB_DATA_W-1:0] array_rdata_i,
  input wire logic sector_protected_i,
  input wire logic erase_busy_i,
  output logic erase_start_o,
  output fpb_erase_cmd_t erase_cmd_o,
  output logic erase_abort_o
);
  localparam int SW = `FPB_SYNC_W + `FPB_ADDR_W + `FPB_DATA_W;
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins;
  logic ce_n, oe_n, we_n, avd_n, bclk, rst_pin_n;
  logic [`FPB_ADDR_W-1:0] addr;
  logic [`FPB_DATA_W-1:0] din;
  logic avd_d_q, bclk_d_q, we_d_q, ce_d_q;
  logic avd_rise, bclk_edge, we_rise, active, halted;
  fpb_state_t st_q;
  logic [`FPB_ADDR_W-1:0] page_base_q;
  logic [`FPB_ADDR_W-1:0] last_addr_q;
  logic [`FPB_ADDR_W-1:0] fetch_addr_q;
  logic [`FPB_ADDR_W-1:0] out_addr_q;
  logic [`FPB_ADDR_W-1:0] page_addr;
  logic [`FPB_ADDR_W-1:0] fetch_next;
  logic [`FPB_ADDR_W-1:0] page_mask;
  logic [`FPB_TMR_W-1:0] tmr_q;
  logic [2:0] lat_q;
  logic [2:0] lat_cfg;
  logic [4:0] len_words;
  logic [4:0] fetched_q;
  logic [4:0] out_cnt_q;
  logic gap_pend_q, pend_q, discard_q, page_rdy_q, valid_q, cmd_armed_q;
  logic fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush, fifo_push;
  logic [`FPB_DATA_W-1:0] fifo_data;
  logic fetch_go, burst_st, page_chg, pop_now, gap_now;

  // every pin crosses into the system clock through the synchroniser
  assign pins_raw = {chip_sel_n_i, out_en_n_i, write_n_i, addr_valid_n_i,
                     burst_clk_i, reset_n_i, addr_i, data_i};
  fpb_sync #(.WIDTH(SW), .INIT({6'h3d, {(SW-6){1'b0}}})) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(pins_raw),
    .level_o(pins)
  );
  assign {ce_n, oe_n, we_n, avd_n, bclk, rst_pin_n, addr, din} = pins;

  // edge history of the filtered pins
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      avd_d_q <= 1'b1;
      bclk_d_q <= 1'b0;
      we_d_q <= 1'b1;
      ce_d_q <= 1'b1;
    end else begin
      avd_d_q <= avd_n;
      bclk_d_q <= bclk;
      we_d_q <= we_n;
      ce_d_q <= ce_n;
    end
  end
  assign avd_rise = avd_n && !avd_d_q;
  // active edge chosen by the clock edge bit, one means rising
  assign bclk_edge = cfg_i.clock_edge_bit ? (bclk && !bclk_d_q) :
                     (!bclk && bclk_d_q);
  assign we_rise = we_n && !we_d_q;
  assign halted = !rst_pin_n;
  assign active = !ce_n && !halted;
  // a suspended burst sees no edges since enable gates them
  assign burst_st = (st_q == FPB_BLAT) || (st_q == FPB_BDATA) ||
                    (st_q == FPB_BGAP) || (st_q == FPB_BDONE);

  // out-of-range codes clamp into the two to six window
  assign lat_cfg = (cfg_i.latency_field < `FPB_LAT_MIN) ? `FPB_LAT_MIN :
                   (cfg_i.latency_field > `FPB_LAT_MAX) ? `FPB_LAT_MAX :
                   cfg_i.latency_field;
  always_comb begin
    case (cfg_i.burst_len)
      `FPB_LEN_4: len_words = 5'h04;
      `FPB_LEN_8: len_words = 5'h08;
      `FPB_LEN_16: len_words = 5'h10;
      default: len_words = 5'h00;
    endcase
  end

  // page bits above the word select, live while the strobe is held low
  assign page_mask = cfg_i.page_size_bit ? 23'h7ffff8 : 23'h7ffffc;
  assign page_addr = avd_n ? ((page_base_q & page_mask) | (addr & ~page_mask)) :
                     addr;
  assign page_chg = ((page_addr & page_mask) != (last_addr_q & page_mask));

  // next fetch address, wrapping inside the burst length when wrap is clear
  always_comb begin
    fetch_next = fetch_addr_q + 23'h000001;
    if (!cfg_i.burst_wrap_bit && (len_words != 5'h00)) begin
      fetch_next = (fetch_addr_q & ~23'(len_words - 5'h01)) |
                   ((fetch_addr_q + 23'h000001) & 23'(len_words - 5'h01));
    end
  end

  // sensing runs ahead of the output, also while suspended
  assign fetch_go = burst_st && !pend_q && fifo_in_ready && !halted &&
                    ((len_words == 5'h00) || (fetched_q != len_words));
  assign fifo_push = array_rvalid_i && burst_st && !discard_q;
  assign pop_now = bclk_edge && !oe_n && fifo_out_valid &&
                   (((st_q == FPB_BLAT) && (lat_q == 3'h1)) ||
                    ((st_q == FPB_BGAP) && (lat_q == 3'h1)) ||
                    ((st_q == FPB_BDATA) && !gap_now));
  // first crossing of a sixteen word group when start sat at 13 to 15
  assign gap_now = gap_pend_q &&
                   (out_addr_q[`FPB_GRP_W-1:0] == {`FPB_GRP_W{1'b1}});
  assign fifo_pop = pop_now;
  assign fifo_flush = !active;

  fpb_fifo #(.WIDTH(`FPB_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(array_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // read sequencer: page path or burst path by read type
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !active) begin
      st_q <= FPB_IDLE;
      lat_q <= 3'h0;
      gap_pend_q <= 1'b0;
      out_cnt_q <= 5'h00;
      out_addr_q <= '0;
    end else begin
      case (st_q)
        FPB_IDLE: begin
          if (cfg_i.read_type_bit) begin
            st_q <= FPB_PAGE;
          end else if (avd_rise || (!avd_n && bclk_edge)) begin
            st_q <= FPB_BLAT;
            lat_q <= lat_cfg;
            out_addr_q <= addr;
            gap_pend_q <= cfg_i.linear_burst_bit && cfg_i.burst_wrap_bit &&
                          (addr[`FPB_GRP_W-1:0] >= `FPB_GAP_FIRST);
          end
        end
        FPB_PAGE: begin
          if (!cfg_i.read_type_bit) begin
            st_q <= FPB_IDLE;
          end
        end
        FPB_BLAT, FPB_BGAP: begin
          if (bclk_edge && !oe_n && (lat_q > 3'h1)) begin
            lat_q <= lat_q - 3'h1;
          end else if (pop_now) begin
            st_q <= FPB_BDATA;
            out_cnt_q <= out_cnt_q + 5'h01;
          end
        end
        FPB_BDATA: begin
          if (bclk_edge && !oe_n) begin
            if ((len_words != 5'h00) && (out_cnt_q == len_words)) begin
              st_q <= FPB_BDONE;
            end else if (gap_now) begin
              st_q <= FPB_BGAP;
              lat_q <= lat_cfg;
              gap_pend_q <= 1'b0; // gap happens only once
            end else if (pop_now) begin
              out_cnt_q <= out_cnt_q + 5'h01;
              out_addr_q <= out_addr_q + 23'h000001;
            end
          end
        end
        default: st_q <= FPB_BDONE;
      endcase
    end
  end

  // array request engine, one read in flight
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      array_rd_o <= 1'b0;
      array_addr_o <= '0;
      fetch_addr_q <= '0;
      fetched_q <= 5'h00;
      pend_q <= 1'b0;
      discard_q <= 1'b0;
      page_base_q <= '0;
      last_addr_q <= '0;
      tmr_q <= '0;
      page_rdy_q <= 1'b0;
    end else begin
      array_rd_o <= 1'b0;
      if (array_rvalid_i) begin
        pend_q <= 1'b0;
        discard_q <= 1'b0;
      end
      if (avd_rise) begin
        page_base_q <= addr;
      end
      if (!active || (st_q == FPB_IDLE)) begin
        // a stale answer still in flight is dropped, then the mark clears
        discard_q <= (pend_q || discard_q) && !array_rvalid_i;
        fetched_q <= 5'h00;
        fetch_addr_q <= addr;
        page_rdy_q <= 1'b0;
        tmr_q <= `FPB_TMR_W'(`FPB_FIRST_CYC);
        last_addr_q <= page_addr;
        if (active && cfg_i.read_type_bit && !pend_q) begin
          array_rd_o <= 1'b1; // first word of the page
          array_addr_o <= page_addr;
          pend_q <= 1'b1;
        end
      end else if (st_q == FPB_PAGE) begin
        // clock input has no effect in this state
        if (page_addr != last_addr_q && !pend_q) begin
          tmr_q <= page_chg ? `FPB_TMR_W'(`FPB_FIRST_CYC) :
                   `FPB_TMR_W'(`FPB_PAGE_CYC);
          last_addr_q <= page_addr;
          page_rdy_q <= 1'b0;
          array_rd_o <= 1'b1;
          array_addr_o <= page_addr;
          pend_q <= 1'b1;
        end else begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end
          if (array_rvalid_i && !discard_q) begin
            page_rdy_q <= 1'b1;
          end
        end
      end else if (fetch_go) begin
        array_rd_o <= 1'b1;
        array_addr_o <= fetch_addr_q;
        fetch_addr_q <= fetch_next;
        fetched_q <= fetched_q + 5'h01;
        pend_q <= 1'b1;
      end
    end
  end

  // output drivers, floated by select, enable and the reset pin
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      data_o <= '0;
      data_oe_o <= 1'b0;
      wait_o <= 1'b0;
      wait_oe_o <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      data_oe_o <= active && !oe_n;
      wait_oe_o <= active && !oe_n && burst_st;
      if (!active) begin
        valid_q <= 1'b0;
      end else if (pop_now) begin
        data_o <= fifo_data;
        valid_q <= 1'b1;
      end else if (bclk_edge && !oe_n && burst_st) begin
        valid_q <= (st_q == FPB_BDONE) && valid_q; // valid cleared on the edge into done and kept low there
      end
      if ((st_q == FPB_PAGE) && array_rvalid_i && !discard_q) begin
        data_o <= array_rdata_i; // shown once the access time ran out
      end
      // default polarity: low while no new data
      wait_o <= valid_q ^ cfg_i.wait_polarity_bit;
      if (st_q == FPB_PAGE) begin
        data_oe_o <= active && !oe_n && page_rdy_q && (tmr_q == '0);
      end
    end
  end

  // erase command decoder, two writes, taken on the strobe rising edge
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || halted) begin
      cmd_armed_q <= 1'b0;
      erase_start_o <= 1'b0;
      erase_cmd_o <= '{kind: FPB_ER_CHIP, addr: '0};
    end else begin
      erase_start_o <= 1'b0;
      if (we_rise && !ce_n && oe_n) begin
        cmd_armed_q <= (din[`FPB_CMD_BYTE_W-1:0] == `FPB_CMD_SETUP);
        if (cmd_armed_q) begin
          // pins at the second strobe rise, not the read page latch
          erase_cmd_o.addr <= addr;
          case (din[`FPB_CMD_BYTE_W-1:0])
            `FPB_CMD_CHIP: begin
              erase_cmd_o.kind <= FPB_ER_CHIP;
              erase_start_o <= 1'b1;
            end
            `FPB_CMD_PLANE: begin
              erase_cmd_o.kind <= FPB_ER_PLANE;
              erase_start_o <= 1'b1;
            end
            `FPB_CMD_SECTOR: begin
              erase_cmd_o.kind <= FPB_ER_SECTOR;
              erase_start_o <= !sector_protected_i;
            end
            default: erase_start_o <= 1'b0;
          endcase
        end
      end
    end
  end

  // reset pin during an erase stops it; the array content is then unknown
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      erase_abort_o <= 1'b0;
    end else begin
      erase_abort_o <= halted && erase_busy_i;
    end
  end
endmodule : fpb_top
